//--- hdl/pdl_lock_filter.sv
// Digital low-pass of the combined pump signal.
// Assumes busy comes from a flip-flop in the same clock domain.
`timescale 1ns/1ns
module pdl_lock_filter (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic busy,
	output logic locked
);
	logic [pdl_pkg::LOCK_CNT_W-1:0] quiet_reg;
	localparam logic [pdl_pkg::LOCK_CNT_W-1:0] LAST =
		pdl_pkg::LOCK_CNT_W'(pdl_pkg::LOCK_CYCLES - 1);
	// Any pump activity restarts the quiet count at once
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			quiet_reg <= '0;
			locked <= 1'b0;
		end else if (busy) begin
			quiet_reg <= '0;
			locked <= 1'b0;
		end else if (quiet_reg == LAST) begin
			locked <= 1'b1;
		end else begin
			quiet_reg <= quiet_reg + 1'b1;
		end
	end
endmodule

//--- hdl/pdl_pkg.sv
// Shared constants and types of the phase detector and lock monitor.
// Assumes a single 100 MHz clock and a 32-bit Avalon-MM register slave.
package pdl_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// Quiet time of the combined signal before lock is declared
	localparam int LOCK_TIME_NS = 1000;
	localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOCK_CNT_W = 8;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int SYNC_W = 5;
	localparam logic [ADDR_W-1:0] ADDR_ENH = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 5'h0C;
	localparam logic [ADDR_W-1:0] ADDR_LIVE = 5'h10;
	localparam logic [7:0] ENH_RESET = 8'h00;
	localparam logic [3:0] IRQ_EN_RESET = 4'h0;
	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
	typedef struct packed {
		logic [3:0] spare;
		logic dout_en;
		logic dout_sel_pre;
		logic ref_mon_off;
		logic main_mon_off;
	} pdl_enh_t;
	typedef struct packed {
		logic lock_lost;
		logic lock_gained;
		logic up_pulse;
		logic down_pulse;
	} pdl_evt_t;
	// Pin inputs after the two-flop synchroniser
	typedef struct packed {
		logic enh_n;
		logic pre_raw;
		logic modulus_select;
		logic ref_div;
		logic main_div;
	} pdl_pins_t;
	typedef enum logic [1:0] {
		PFD_IDLE,
		PFD_UP,
		PFD_DOWN
	} pdl_pfd_state_t;
endpackage

//--- hdl/pdl_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the inputs are slow compared with the 100 MHz clock.
`timescale 1ns/1ns
module pdl_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

//--- hdl/pdl_top.sv
// Phase detector output stage, lock indication and monitor pins.
// Assumes divider outputs and mode pins arrive asynchronously on pins.
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
module pdl_top (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic main_div_in,
	input wire logic reference_input,
	input wire logic modulus_select,
	input wire logic prescaler_raw,
	input wire logic enh_mode_n,
	input wire logic [pdl_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [pdl_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [pdl_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic pump_up_n,
	output logic pump_down_n,
	output logic combined_lock,
	output logic lock_detect_od_o,
	output logic lock_detect_od_oe,
	output logic main_div_monitor,
	output logic ref_div_monitor,
	output logic data_out,
	output logic irq
);
	pdl_pkg::pdl_pins_t pins_raw;
	pdl_pkg::pdl_pins_t pins;
	pdl_pkg::pdl_enh_t enh_reg;
	pdl_pkg::pdl_evt_t evt;
	pdl_pkg::pdl_evt_t status_reg;
	pdl_pkg::pdl_evt_t clear_mask;
	pdl_pkg::pdl_evt_t irq_en_reg;
	pdl_pkg::pdl_pfd_state_t state_reg;
	pdl_pkg::pdl_pfd_state_t state_next;
	logic main_prev_reg;
	logic ref_prev_reg;
	logic main_edge;
	logic ref_edge;
	logic enh_active;
	logic locked;
	logic locked_prev_reg;
	logic ack_reg;
	logic wr_take;
	logic [pdl_pkg::DATA_W-1:0] rd_next;

	assign pins_raw = '{
		enh_n: enh_mode_n,
		pre_raw: prescaler_raw,
		modulus_select: modulus_select,
		ref_div: reference_input,
		main_div: main_div_in
	};

	pdl_sync #(
		.W(pdl_pkg::SYNC_W)
	) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d(pins_raw),
		.q(pins)
	);

	// Edge detectors read only the second synchroniser stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			main_prev_reg <= 1'b0;
			ref_prev_reg <= 1'b0;
		end else begin
			main_prev_reg <= pins.main_div;
			ref_prev_reg <= pins.ref_div;
		end
	end

	assign main_edge = pins.main_div && !main_prev_reg;
	assign ref_edge = pins.ref_div && !ref_prev_reg;
	assign enh_active = !pins.enh_n;

	// Phase-frequency detector
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			pdl_pkg::PFD_IDLE: begin
				if (main_edge && !ref_edge) begin
					state_next = pdl_pkg::PFD_DOWN;
				end else if (ref_edge && !main_edge) begin
					state_next = pdl_pkg::PFD_UP;
				end
			end
			pdl_pkg::PFD_UP: begin
				if (main_edge) begin
					state_next = pdl_pkg::PFD_IDLE;
				end
			end
			pdl_pkg::PFD_DOWN: begin
				if (ref_edge) begin
					state_next = pdl_pkg::PFD_IDLE;
				end
			end
			default: begin
				state_next = pdl_pkg::PFD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= pdl_pkg::PFD_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Pump pins are registered so they carry no decode glitches
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pump_up_n <= 1'b1;
			pump_down_n <= 1'b1;
		end else begin
			pump_up_n <= state_next != pdl_pkg::PFD_UP;
			pump_down_n <= state_next != pdl_pkg::PFD_DOWN;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			combined_lock <= 1'b0;
		end else begin
			combined_lock <= !(pump_up_n && pump_down_n);
		end
	end

	pdl_lock_filter u_filter (
		.clk(clk),
		.arst_n(arst_n),
		.busy(combined_lock),
		.locked(locked)
	);

	// Open drain: only ever pulls low
	assign lock_detect_od_o = 1'b0;
	assign lock_detect_od_oe = !locked;

	// Monitor and data-out pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			main_div_monitor <= 1'b0;
			ref_div_monitor <= 1'b0;
		end else begin
			main_div_monitor <= pins.main_div && !(enh_active && enh_reg.main_mon_off);
			ref_div_monitor <= pins.ref_div && !(enh_active && enh_reg.ref_mon_off);
		end
	end

	// Idle low when not selected, so the pin never floats
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out <= 1'b0;
		end else if (enh_active && enh_reg.dout_en) begin
			data_out <= enh_reg.dout_sel_pre ? pins.pre_raw : pins.modulus_select;
		end else begin
			data_out <= 1'b0;
		end
	end

	// Events and interrupt
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			locked_prev_reg <= 1'b0;
		end else begin
			locked_prev_reg <= locked;
		end
	end

	assign evt = '{
		lock_lost: locked_prev_reg && !locked,
		lock_gained: locked && !locked_prev_reg,
		up_pulse: state_next == pdl_pkg::PFD_UP && state_reg != pdl_pkg::PFD_UP,
		down_pulse: state_next == pdl_pkg::PFD_DOWN && state_reg != pdl_pkg::PFD_DOWN
	};

	assign wr_take = avs_write && ack_reg;
	assign clear_mask = (wr_take && avs_address == pdl_pkg::ADDR_IRQ_CLEAR && avs_byteenable[0]) ?
		pdl_pkg::pdl_evt_t'(avs_writedata[3:0]) : '0;

	// A new event beats a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg & ~clear_mask) | evt;
		end
	end

	assign irq = |(status_reg & irq_en_reg);

	// Avalon slave: one wait state on every access
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read || avs_write) && !ack_reg;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enh_reg <= pdl_pkg::pdl_enh_t'(pdl_pkg::ENH_RESET);
		end else if (wr_take && avs_address == pdl_pkg::ADDR_ENH && avs_byteenable[0]) begin
			enh_reg <= pdl_pkg::pdl_enh_t'(avs_writedata[7:0]);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_en_reg <= pdl_pkg::pdl_evt_t'(pdl_pkg::IRQ_EN_RESET);
		end else if (wr_take && avs_address == pdl_pkg::ADDR_IRQ_ENABLE && avs_byteenable[0]) begin
			irq_en_reg <= pdl_pkg::pdl_evt_t'(avs_writedata[3:0]);
		end
	end

	// Unmapped and write-only addresses read as zero
	always_comb begin
		rd_next = pdl_pkg::RD_ZERO;
		unique case (avs_address)
			pdl_pkg::ADDR_ENH: rd_next[7:0] = enh_reg;
			pdl_pkg::ADDR_IRQ_STATUS: rd_next[3:0] = status_reg;
			pdl_pkg::ADDR_IRQ_ENABLE: rd_next[3:0] = irq_en_reg;
			pdl_pkg::ADDR_LIVE: rd_next[5:0] = {enh_active, combined_lock, locked,
				pump_up_n, pump_down_n, irq};
			default: rd_next = pdl_pkg::RD_ZERO;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= pdl_pkg::RD_ZERO;
		end else if (avs_read && !ack_reg) begin
			avs_readdata <= rd_next;
		end
	end

	// Checks
	sequence s_idle_main_only;
		state_reg == pdl_pkg::PFD_IDLE && main_edge && !ref_edge;
	endsequence
	sequence s_idle_ref_only;
		state_reg == pdl_pkg::PFD_IDLE && ref_edge && !main_edge;
	endsequence
	sequence s_down_then_ref;
		!pump_down_n ##0 (state_reg == pdl_pkg::PFD_DOWN && ref_edge);
	endsequence
	sequence s_up_then_main;
		!pump_up_n ##0 (state_reg == pdl_pkg::PFD_UP && main_edge);
	endsequence

	AST_PUMP_DOWN: assert property (@(posedge clk) disable iff (!arst_n)
		s_idle_main_only |=> !pump_down_n && pump_up_n)
		else $error("pump down not asserted after leading main edge");
	AST_PUMP_UP: assert property (@(posedge clk) disable iff (!arst_n)
		s_idle_ref_only |=> !pump_up_n && pump_down_n)
		else $error("pump up not asserted after leading reference edge");
	AST_LOCK_NAND: assert property (@(posedge clk) disable iff (!arst_n)
		##1 combined_lock == !($past(pump_up_n) && $past(pump_down_n)))
		else $error("combined lock is not the nand of the pump outputs");
	AST_LOCK_PIN_LOW: assert property (@(posedge clk) disable iff (!arst_n)
		combined_lock |=> lock_detect_od_oe && !lock_detect_od_o)
		else $error("lock detect not pulled low on pump activity");
	AST_MAIN_MON: assert property (@(posedge clk) disable iff (!arst_n)
		enh_active && enh_reg.main_mon_off |=> !main_div_monitor)
		else $error("main monitor switching while suppressed");
	AST_REF_MON: assert property (@(posedge clk) disable iff (!arst_n)
		!(enh_active && enh_reg.ref_mon_off) |=> ref_div_monitor == $past(pins.ref_div))
		else $error("reference monitor does not follow the divider");
	AST_DOUT_SEL: assert property (@(posedge clk) disable iff (!arst_n)
		enh_active && enh_reg.dout_en && !enh_reg.dout_sel_pre
		|=> data_out == $past(pins.modulus_select))
		else $error("data out does not carry modulus select");
	AST_ENH_GATE: assert property (@(posedge clk) disable iff (!arst_n)
		!enh_active |=> !data_out && main_div_monitor == $past(pins.main_div))
		else $error("enhancement bits acting while mode input is high");
	AST_PFD_END_DN: assert property (@(posedge clk) disable iff (!arst_n)
		s_down_then_ref |=> pump_down_n && pump_up_n)
		else $error("pump down not ended after reference edge");
	AST_PFD_END_UP: assert property (@(posedge clk) disable iff (!arst_n)
		s_up_then_main |=> pump_up_n && pump_down_n)
		else $error("pump up not ended after main edge");
	AST_STICKY: assert property (@(posedge clk) disable iff (!arst_n)
		evt.lock_lost |=> status_reg.lock_lost)
		else $error("event lost against a clear");

	// Own quiet count, apart from the filter, so a slip in either shows
	localparam logic [pdl_pkg::LOCK_CNT_W-1:0] QUIET_FULL =
		pdl_pkg::LOCK_CNT_W'(pdl_pkg::LOCK_CYCLES);
	logic [pdl_pkg::LOCK_CNT_W-1:0] quiet_ref_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			quiet_ref_reg <= '0;
		end else if (combined_lock) begin
			quiet_ref_reg <= '0;
		end else if (quiet_ref_reg != QUIET_FULL) begin
			quiet_ref_reg <= quiet_ref_reg + 1'b1;
		end
	end

	AST_LOCK_PIN_TIME: assert property (@(posedge clk) disable iff (!arst_n)
		lock_detect_od_oe == (quiet_ref_reg != QUIET_FULL))
		else $error("lock detect released at the wrong time");
	AST_MAIN_MON_ON: assert property (@(posedge clk) disable iff (!arst_n)
		!(enh_active && enh_reg.main_mon_off) |=> main_div_monitor == $past(pins.main_div))
		else $error("main monitor does not follow the divider");
	AST_REF_MON_OFF: assert property (@(posedge clk) disable iff (!arst_n)
		enh_active && enh_reg.ref_mon_off |=> !ref_div_monitor)
		else $error("reference monitor switching while suppressed");
	AST_DOUT_PRE: assert property (@(posedge clk) disable iff (!arst_n)
		enh_active && enh_reg.dout_en && enh_reg.dout_sel_pre
		|=> data_out == $past(pins.pre_raw))
		else $error("data out does not carry the prescaler output");
	AST_DOUT_DIS: assert property (@(posedge clk) disable iff (!arst_n)
		enh_active && !enh_reg.dout_en |=> !data_out)
		else $error("data out active while disabled");
	AST_PUMP_EXCL: assert property (@(posedge clk) disable iff (!arst_n)
		pump_up_n || pump_down_n)
		else $error("both pump outputs low together");
	AST_COINCIDENT: assert property (@(posedge clk) disable iff (!arst_n)
		state_reg == pdl_pkg::PFD_IDLE && main_edge && ref_edge |=> pump_up_n && pump_down_n)
		else $error("pump pulse on coincident divider edges");
	AST_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
		clear_mask.lock_gained && !evt.lock_gained |=> !status_reg.lock_gained)
		else $error("status bit not cleared by a clear write");
	AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
		avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	AST_STICKY_UP: assert property (@(posedge clk) disable iff (!arst_n)
		evt.up_pulse |=> status_reg.up_pulse)
		else $error("up pulse event not recorded");
endmodule

//--- verif/pdl_pump_model.sv
// Far-side model: charge pump and pull-up on the lock pin.
// Assumes pump outputs are registered on clk.
`timescale 1ns/1ns
module pdl_pump_model (
	input wire logic clk,
	input wire logic pump_up_n,
	input wire logic pump_down_n,
	input wire logic od_o,
	input wire logic od_oe,
	output logic lock_pin,
	output logic [15:0] up_cnt,
	output logic [15:0] dn_cnt
);
	logic [15:0] up_q = 16'h0000;
	logic [15:0] dn_q = 16'h0000;
	// Pull-up when released, so no stale level shows
	assign lock_pin = od_oe ? od_o : 1'b1;
	assign up_cnt = up_q;
	assign dn_cnt = dn_q;
	// Charge delivered, counted in clock cycles
	always @(posedge clk) begin
		if (pump_up_n === 1'b0) begin
			up_q <= up_q + 16'h0001;
		end
		if (pump_down_n === 1'b0) begin
			dn_q <= dn_q + 16'h0001;
		end
	end
endmodule

//--- verif/testbench.sv
// Self-checking bench of the phase detector and lock monitor.
// Assumes the pump model and the design files are compiled first.
`timescale 1ns/1ns
module testbench;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic main_div_in = 1'b0;
	logic reference_input = 1'b0;
	logic modulus_select = 1'b0;
	logic prescaler_raw = 1'b0;
	logic enh_mode_n = 1'b1;
	logic [pdl_pkg::ADDR_W-1:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, pump_up_n, pump_down_n, combined_lock;
	logic od_o, od_oe, main_mon, ref_mon, data_out, irq, lock_pin;
	logic [15:0] up_cnt, dn_cnt;
	logic [31:0] rd;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	pdl_top DUT (.clk(clk), .arst_n(arst_n), .main_div_in(main_div_in),
		.reference_input(reference_input), .modulus_select(modulus_select),
		.prescaler_raw(prescaler_raw), .enh_mode_n(enh_mode_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pump_up_n(pump_up_n), .pump_down_n(pump_down_n),
		.combined_lock(combined_lock), .lock_detect_od_o(od_o),
		.lock_detect_od_oe(od_oe), .main_div_monitor(main_mon),
		.ref_div_monitor(ref_mon), .data_out(data_out), .irq(irq));
	pdl_pump_model pump (.clk(clk), .pump_up_n(pump_up_n), .pump_down_n(pump_down_n),
		.od_o(od_o), .od_oe(od_oe), .lock_pin(lock_pin), .up_cnt(up_cnt), .dn_cnt(dn_cnt));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask
	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic pins(input logic m, input logic r);
		@(posedge clk);
		main_div_in <= m;
		reference_input <= r;
	endtask
	task automatic mode(input logic e, input logic ms, input logic pr);
		@(posedge clk);
		enh_mode_n <= e;
		modulus_select <= ms;
		prescaler_raw <= pr;
	endtask
	task automatic t_regs();
		chk({pump_up_n, pump_down_n, od_oe, irq}, 4'hE, "reset outputs");
		bus(0, pdl_pkg::ADDR_LIVE, 0);
		chk(rd, 32'h0000_0006, "live after reset");
		bus(0, pdl_pkg::ADDR_ENH, 0);
		chk(rd, 32'h0000_0000, "enh reset");
		bus(0, pdl_pkg::ADDR_IRQ_ENABLE, 0);
		chk(rd, 32'h0000_0000, "enable reset");
		bus(1, pdl_pkg::ADDR_ENH, 32'h0000_00A5);
		bus(1, 5'h14, 32'h0000_00FF);
		bus(0, 5'h14, 0);
		chk(rd, 32'h0000_0000, "unmapped read");
		bus(0, pdl_pkg::ADDR_ENH, 0);
		chk(rd, 32'h0000_00A5, "enh readback");
		bus(1, pdl_pkg::ADDR_ENH, 0);
		$display("test regs done");
	endtask
	// Gap of nine cycles between edges gives a nine-cycle pulse
	task automatic t_pfd(input logic mf);
		logic [15:0] u0, d0;
		u0 = up_cnt;
		d0 = dn_cnt;
		pins(mf, ~mf);
		repeat (5) @(posedge clk);
		chk({pump_up_n, pump_down_n, combined_lock}, mf ? 3'b101 : 3'b011, "lead");
		repeat (3) @(posedge clk);
		pins(1, 1);
		repeat (6) @(posedge clk);
		chk({pump_up_n, pump_down_n, combined_lock}, 3'b110, "release");
		chk(mf ? dn_cnt - d0 : up_cnt - u0, 16'h0009, "pulse width");
		chk(mf ? up_cnt - u0 : dn_cnt - d0, 16'h0000, "wrong pump");
		pins(0, 0);
		repeat (4) @(posedge clk);
		u0 = up_cnt;
		d0 = dn_cnt;
		pins(1, 1);
		repeat (8) @(posedge clk);
		chk({up_cnt - u0, dn_cnt - d0}, 32'h0000_0000, "coincident edges");
		pins(0, 0);
		repeat (4) @(posedge clk);
		$display("test pfd done");
	endtask
	task automatic t_lock();
		bus(1, pdl_pkg::ADDR_IRQ_CLEAR, 32'h0000_000F);
		bus(1, pdl_pkg::ADDR_IRQ_ENABLE, 32'h0000_0004);
		pins(1, 0);
		repeat (4) @(posedge clk);
		pins(1, 1);
		repeat (94) @(posedge clk);
		chk({od_oe, lock_pin}, 2'b10, "early lock");
		repeat (20) @(posedge clk);
		chk({od_oe, lock_pin, irq}, 3'b011, "locked");
		bus(0, pdl_pkg::ADDR_IRQ_STATUS, 0);
		chk(rd & 32'h0000_0004, 32'h0000_0004, "lock status");
		bus(1, pdl_pkg::ADDR_IRQ_ENABLE, 0);
		@(posedge clk);
		chk(irq, 1'b0, "irq masked");
		bus(1, pdl_pkg::ADDR_IRQ_CLEAR, 32'h0000_0004);
		bus(0, pdl_pkg::ADDR_IRQ_STATUS, 0);
		chk(rd & 32'h0000_0004, 32'h0000_0000, "status cleared");
		pins(0, 0);
		repeat (3) @(posedge clk);
		pins(1, 0);
		repeat (6) @(posedge clk);
		chk({od_oe, lock_pin}, 2'b10, "lock lost");
		bus(0, pdl_pkg::ADDR_IRQ_STATUS, 0);
		chk(rd, 32'h0000_0009, "event status");
		pins(1, 1);
		repeat (4) @(posedge clk);
		pins(0, 0);
		$display("test lock done");
	endtask
	task automatic t_mon();
		logic [1:0] held;
		bus(1, pdl_pkg::ADDR_ENH, 32'h0000_000F);
		mode(1, 0, 1);
		pins(1, 0);
		repeat (6) @(posedge clk);
		chk({main_mon, ref_mon, data_out}, 3'b100, "enh inactive");
		mode(0, 0, 1);
		repeat (6) @(posedge clk);
		held = {main_mon, ref_mon};
		pins(0, 1);
		repeat (6) @(posedge clk);
		chk({main_mon, ref_mon}, held, "monitors frozen");
		chk(data_out, 1'b1, "prescaler out");
		bus(1, pdl_pkg::ADDR_ENH, 32'h0000_0008);
		mode(0, 1, 0);
		repeat (6) @(posedge clk);
		chk({main_mon, ref_mon, data_out}, 3'b011, "modulus out");
		bus(1, pdl_pkg::ADDR_ENH, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk(data_out, 1'b0, "dout disabled");
		bus(1, pdl_pkg::ADDR_ENH, 32'h0000_0008);
		mode(1, 1, 1);
		pins(0, 0);
		repeat (6) @(posedge clk);
		chk(data_out, 1'b0, "dout idle");
		$display("test mon done");
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_pfd(1);
		t_pfd(0);
		t_lock();
		t_mon();
		wrap_up();
	end
endmodule
